// ===== mvtwf_pkg.sv
package mvtwf_pkg;

	// ---------------------------------------------------------------
	// Register map, indexed by word on the plain register port
	// ---------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_TAG1 = 4'h9;
	localparam logic [ADDR_W-1:0] OFS_TAG2 = 4'hA;
	localparam logic [ADDR_W-1:0] OFS_FILT = 4'hB;
	localparam logic [ADDR_W-1:0] OFS_WCSR = 4'hC;
	localparam logic [ADDR_W-1:0] OFS_ISTAT = 4'hD;
	localparam logic [ADDR_W-1:0] OFS_IMASK = 4'hE;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_TAG = 16'h0000;

	// ---------------------------------------------------------------
	// Wake control and status bit positions
	// ---------------------------------------------------------------
	localparam int WCSR_UNI_EN = 9;
	localparam int WCSR_FRAME_SEEN = 6;
	localparam int WCSR_PKT_SEEN = 5;
	localparam int WCSR_FRAME_EN = 2;
	localparam int WCSR_PKT_EN = 1;

	// Interrupt status and mask bit positions.
	localparam int IRQ_W = 4;
	localparam int IRQ_FRAME = 0;
	localparam int IRQ_PKT = 1;
	localparam int IRQ_UNI = 2;
	localparam int IRQ_OVER = 3;

	// ---------------------------------------------------------------
	// Frame geometry
	// ---------------------------------------------------------------
	localparam int POS_W = 12;
	localparam logic [POS_W-1:0] POS_MAX = 12'hFFE;
	localparam logic [POS_W-1:0] POS_TAG_HI = 12'h00C;
	localparam logic [POS_W-1:0] POS_TAG_LO = 12'h00D;
	localparam logic [POS_W-1:0] POS_DA0 = 12'h000;
	localparam logic [POS_W-1:0] LEN_UNTAGGED = 12'd1518;
	localparam logic [POS_W-1:0] LEN_TAGGED = 12'd1522;

	// ---------------------------------------------------------------
	// Wake filter table and address-repeat packet
	// ---------------------------------------------------------------
	localparam int FLT_WORDS = 8;
	localparam int FLT_PTR_W = 3;
	localparam int FLT_MASK = 0;
	localparam int FLT_CMD = 4;
	localparam int FLT_CRC = 6;
	localparam logic [POS_W-1:0] FLT_SPAN = 12'd32;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [7:0] SYNC_BYTE = 8'hFF;
	localparam logic [2:0] SYNC_RUN = 3'd6;
	localparam logic [2:0] ADDR_LAST = 3'd5;
	localparam logic [3:0] REP_LAST = 4'd15;

	typedef enum logic [1:0] {
		MP_HUNT = 2'b00,
		MP_ADDR = 2'b01,
		MP_FOUND = 2'b10
	} mvtwf_mp_state_t;

endpackage

// ===== mvtwf_wake_if.sv
`timescale 1ns/1ns
// Carries filter loads and the receive byte stream to the filter table.
interface mvtwf_wake_if;
	logic load_en;
	logic [31:0] load_data;
	logic rx_valid;
	logic rx_sof;
	logic [7:0] rx_data;
	logic [11:0] byte_pos;
	logic frame_match;

	modport source (output load_en, load_data, rx_valid, rx_sof, rx_data, byte_pos,
		input frame_match);
	modport sink (input load_en, load_data, rx_valid, rx_sof, rx_data, byte_pos,
		output frame_match);
endinterface

// ===== mvtwf_filter.sv
`timescale 1ns/1ns
// Wake filter table, loaded through a write-only port, and its frame checker.
module mvtwf_filter import mvtwf_pkg::*; (
	input wire logic sys_clk, // System clock.
	input wire logic reset, // Asynchronous reset, active high.
	mvtwf_wake_if.sink wif // Loads in, match result out.
);

	logic [31:0] table_r [FLT_WORDS];
	logic [31:0] table_nxt [FLT_WORDS];
	logic [FLT_PTR_W-1:0] ptr_r;
	logic [FLT_PTR_W-1:0] ptr_nxt;
	logic [15:0] crc_r;
	logic [15:0] crc_nxt;

	// ---------------------------------------------------------------
	// Load pointer
	// ---------------------------------------------------------------
	// sequential entry load
	// pointer wraps after eight
	// The pointer is three bits wide so the wrap after entry seven is free.
	always_comb begin
		ptr_nxt = ptr_r;
		if (wif.load_en) begin
			ptr_nxt = ptr_r + 3'd1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ptr_r <= '0;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Table storage, one word per entry
	// ---------------------------------------------------------------
	// no read path exists
	for (genvar g = 0; g < FLT_WORDS; g++) begin : g_entry
		assign table_nxt[g] = (wif.load_en && ptr_r == FLT_PTR_W'(g)) ?
			wif.load_data : table_r[g];
		always_ff @(posedge sys_clk or posedge reset) begin
			if (reset) begin
				table_r[g] <= RST_WORD;
			end else begin
				table_r[g] <= table_nxt[g];
			end
		end
	end

	// ---------------------------------------------------------------
	// Masked CRC over the first bytes of the frame
	// ---------------------------------------------------------------
	// Only the byte mask of filter 0 takes part; the mask covers 32 bytes.
	always_comb begin
		logic fb;
		fb = 1'b0;
		crc_nxt = wif.rx_sof ? CRC_INIT : crc_r;
		if (wif.rx_valid && wif.byte_pos < FLT_SPAN &&
			table_r[FLT_MASK][wif.byte_pos[4:0]]) begin
			for (int i = 0; i < 8; i++) begin
				fb = crc_nxt[15] ^ wif.rx_data[i];
				crc_nxt = {crc_nxt[14:0], 1'b0};
				if (fb) begin
					crc_nxt = crc_nxt ^ CRC_POLY;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			crc_r <= CRC_INIT;
		end else if (wif.rx_valid) begin
			crc_r <= crc_nxt;
		end
	end

	assign wif.frame_match = table_r[FLT_CMD][0] && (crc_nxt == table_r[FLT_CRC][15:0]);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	ptr_step_a: assert property (wif.load_en |=> ptr_r == $past(ptr_r) + 3'd1)
		else $error("Filter pointer did not advance on a load.");
	ptr_wrap_a: assert property (wif.load_en && ptr_r == 3'd7 |=> ptr_r == 3'd0)
		else $error("Filter pointer did not wrap after entry seven.");
	entry_load_a: assert property (wif.load_en && ptr_r == 3'd0 |=>
		table_r[0] == $past(wif.load_data))
		else $error("Entry zero did not take the loaded word.");

endmodule

// ===== mvtwf_top.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module mvtwf_top import mvtwf_pkg::*; (
	input wire logic sys_clk, // System clock, 100 MHz.
	input wire logic reset, // Asynchronous reset, active high.
	input wire logic [ADDR_W-1:0] reg_addr, // Register word index.
	input wire logic [31:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [31:0] reg_rdata, // Read data, the cycle after reg_rd.
	input wire logic rx_valid, // Receive byte valid.
	input wire logic rx_sof, // First byte of a frame.
	input wire logic rx_eof, // Last byte of a frame.
	input wire logic rx_good, // Frame passed its checks, with rx_eof.
	input wire logic [7:0] rx_data, // Receive byte.
	input wire logic [47:0] station_addr, // Own address, first byte lowest.
	input wire logic power_save, // Device is in power-saving mode.
	output logic tag1_hit, // Current frame carries the first tag.
	output logic tag2_hit, // Current frame carries the second tag.
	output logic [POS_W-1:0] frame_len_max, // Legal length of current frame.
	output logic oversize, // Pulse: frame ended beyond its legal length.
	output logic wake_event, // Pulse: an enabled wake event occurred.
	output logic irq // Interrupt, high while an unmasked status bit is set.
);

	mvtwf_wake_if wif ();

	logic [15:0] tag1_r, tag1_nxt, tag2_r, tag2_nxt;
	logic uni_en_r, uni_en_nxt, frame_en_r, frame_en_nxt, pkt_en_r, pkt_en_nxt;
	logic frame_seen_r, frame_seen_nxt, pkt_seen_r, pkt_seen_nxt;
	logic [IRQ_W-1:0] istat_r, istat_nxt, imask_r, imask_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic [POS_W-1:0] cnt_r, cnt_nxt, pos;
	logic [7:0] tag_hi_r, tag_hi_nxt;
	logic tag1_hit_r, tag1_hit_nxt, tag2_hit_r, tag2_hit_nxt;
	logic [POS_W-1:0] len_max_r, len_max_nxt;
	logic da0_r, da0_nxt, da0_now;
	logic oversize_r, oversize_nxt, wake_r, wake_nxt;
	mvtwf_mp_state_t mp_r, mp_nxt;
	logic [2:0] run_r, run_nxt, idx_r, idx_nxt;
	logic [3:0] rep_r, rep_nxt;
	logic end_ok, ev_frame, ev_pkt, ev_uni, ev_over;
	logic wr_wcsr, wr_istat;
	logic [31:0] wcsr_view;

	assign reg_rdata = rdata_r;
	assign irq = irq_r;
	assign tag1_hit = tag1_hit_r;
	assign tag2_hit = tag2_hit_r;
	assign frame_len_max = len_max_r;
	assign oversize = oversize_r;
	assign wake_event = wake_r;

	// ---------------------------------------------------------------
	// Filter table
	// ---------------------------------------------------------------
	// loads steered to the table
	assign wif.load_en = reg_wr && reg_addr == OFS_FILT;
	assign wif.load_data = reg_wdata;
	assign wif.rx_valid = rx_valid;
	assign wif.rx_sof = rx_sof;
	assign wif.rx_data = rx_data;
	assign wif.byte_pos = pos;

	mvtwf_filter u_filter (
		.sys_clk(sys_clk),
		.reset(reset),
		.wif(wif)
	);

	// ---------------------------------------------------------------
	// Frame position and tag detection
	// ---------------------------------------------------------------
	// The count saturates so that a runaway frame still reads as too long.
	always_comb begin
		pos = rx_sof ? '0 : cnt_r;
		cnt_nxt = cnt_r;
		tag_hi_nxt = tag_hi_r;
		tag1_hit_nxt = tag1_hit_r;
		tag2_hit_nxt = tag2_hit_r;
		len_max_nxt = len_max_r;
		da0_nxt = da0_r;
		if (rx_valid) begin
			cnt_nxt = (pos == POS_MAX) ? pos : pos + 12'd1;
			if (rx_sof) begin
				tag1_hit_nxt = 1'b0;
				tag2_hit_nxt = 1'b0;
				len_max_nxt = LEN_UNTAGGED;
			end
			if (pos == POS_DA0) begin
				da0_nxt = rx_data[0];
			end
			if (pos == POS_TAG_HI) begin
				tag_hi_nxt = rx_data;
			end
			if (pos == POS_TAG_LO) begin
				tag1_hit_nxt = {tag_hi_r, rx_data} == tag1_r;
				tag2_hit_nxt = {tag_hi_r, rx_data} == tag2_r;
				len_max_nxt = (tag1_hit_nxt || tag2_hit_nxt) ? LEN_TAGGED : LEN_UNTAGGED;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_r <= '0;
			tag_hi_r <= '0;
			tag1_hit_r <= 1'b0;
			tag2_hit_r <= 1'b0;
			len_max_r <= LEN_UNTAGGED;
			da0_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tag_hi_r <= tag_hi_nxt;
			tag1_hit_r <= tag1_hit_nxt;
			tag2_hit_r <= tag2_hit_nxt;
			len_max_r <= len_max_nxt;
			da0_r <= da0_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Address-repeat packet detector
	// ---------------------------------------------------------------
	// packet hunt
	// A mismatch restarts the hunt; an address that itself starts with a sync
	// byte may be missed, which is accepted for a small detector.
	always_comb begin
		mp_nxt = mp_r;
		run_nxt = run_r;
		idx_nxt = idx_r;
		rep_nxt = rep_r;
		if (rx_valid) begin
			if (rx_sof) begin
				mp_nxt = MP_HUNT;
				run_nxt = '0;
			end
			case (rx_sof ? MP_HUNT : mp_r)
				MP_HUNT: begin
					if (rx_data == SYNC_BYTE) begin
						run_nxt = (run_nxt == SYNC_RUN) ? SYNC_RUN : run_nxt + 3'd1;
					end else if (run_nxt == SYNC_RUN && rx_data == station_addr[7:0]) begin
						mp_nxt = MP_ADDR;
						idx_nxt = 3'd1;
						rep_nxt = '0;
					end else begin
						run_nxt = '0;
					end
				end
				MP_ADDR: begin
					if (rx_data == station_addr[8*idx_r +: 8]) begin
						idx_nxt = (idx_r == ADDR_LAST) ? 3'd0 : idx_r + 3'd1;
						if (idx_r == ADDR_LAST) begin
							rep_nxt = rep_r + 4'd1;
							if (rep_r == REP_LAST) begin
								mp_nxt = MP_FOUND;
							end
						end
					end else begin
						mp_nxt = MP_HUNT;
						run_nxt = (rx_data == SYNC_BYTE) ? 3'd1 : 3'd0;
					end
				end
				MP_FOUND: begin
					mp_nxt = MP_FOUND;
				end
				default: begin
					mp_nxt = MP_HUNT;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mp_r <= MP_HUNT;
			run_r <= '0;
			idx_r <= '0;
			rep_r <= '0;
		end else begin
			mp_r <= mp_nxt;
			run_r <= run_nxt;
			idx_r <= idx_nxt;
			rep_r <= rep_nxt;
		end
	end

	// ---------------------------------------------------------------
	// End-of-frame events
	// ---------------------------------------------------------------
	assign end_ok = rx_valid && rx_eof && rx_good;
	assign da0_now = (pos == POS_DA0) ? rx_data[0] : da0_r;
	assign ev_frame = end_ok && frame_en_r && wif.frame_match;
	assign ev_pkt = end_ok && pkt_en_r && mp_nxt == MP_FOUND;
	assign ev_uni = end_ok && uni_en_r && power_save && !da0_now;
	assign ev_over = rx_valid && rx_eof && (pos + 12'd1) > len_max_nxt;

	// ---------------------------------------------------------------
	// Registers, status and interrupt
	// ---------------------------------------------------------------
	assign wr_wcsr = reg_wr && reg_addr == OFS_WCSR;
	assign wr_istat = reg_wr && reg_addr == OFS_ISTAT;
	assign wcsr_view = {22'h0, uni_en_r, 2'b00, frame_seen_r, pkt_seen_r, 2'b00,
		frame_en_r, pkt_en_r, 1'b0};

	// Seen flags and status bits clear on a written one, but a new event in
	// the same cycle wins so that no wake is lost.
	always_comb begin
		tag1_nxt = tag1_r;
		tag2_nxt = tag2_r;
		uni_en_nxt = uni_en_r;
		frame_en_nxt = frame_en_r;
		pkt_en_nxt = pkt_en_r;
		imask_nxt = imask_r;
		frame_seen_nxt = frame_seen_r;
		pkt_seen_nxt = pkt_seen_r;
		istat_nxt = istat_r;
		if (reg_wr && reg_addr == OFS_TAG1) begin
			tag1_nxt = reg_wdata[15:0];
		end
		if (reg_wr && reg_addr == OFS_TAG2) begin
			tag2_nxt = reg_wdata[15:0];
		end
		if (reg_wr && reg_addr == OFS_IMASK) begin
			imask_nxt = reg_wdata[IRQ_W-1:0];
		end
		if (wr_wcsr) begin
			uni_en_nxt = reg_wdata[WCSR_UNI_EN];
			frame_en_nxt = reg_wdata[WCSR_FRAME_EN];
			pkt_en_nxt = reg_wdata[WCSR_PKT_EN];
			frame_seen_nxt = frame_seen_r && !reg_wdata[WCSR_FRAME_SEEN];
			pkt_seen_nxt = pkt_seen_r && !reg_wdata[WCSR_PKT_SEEN];
		end
		if (wr_istat) begin
			istat_nxt = istat_r & ~reg_wdata[IRQ_W-1:0];
		end
		frame_seen_nxt = frame_seen_nxt || ev_frame;
		pkt_seen_nxt = pkt_seen_nxt || ev_pkt;
		istat_nxt = istat_nxt | {ev_over, ev_uni, ev_pkt, ev_frame};
		irq_nxt = |(istat_nxt & imask_nxt);
		wake_nxt = ev_frame || ev_pkt || ev_uni;
		oversize_nxt = ev_over;
	end

	always_comb begin
		rdata_nxt = RST_WORD;
		if (reg_rd) begin
			case (reg_addr)
				OFS_TAG1: rdata_nxt = {16'h0000, tag1_r};
				OFS_TAG2: rdata_nxt = {16'h0000, tag2_r};
				OFS_WCSR: rdata_nxt = wcsr_view;
				OFS_ISTAT: rdata_nxt = {28'h0, istat_r};
				OFS_IMASK: rdata_nxt = {28'h0, imask_r};
				default: rdata_nxt = RST_WORD;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tag1_r <= RST_TAG;
			tag2_r <= RST_TAG;
			uni_en_r <= 1'b0;
			frame_en_r <= 1'b0;
			pkt_en_r <= 1'b0;
			frame_seen_r <= 1'b0;
			pkt_seen_r <= 1'b0;
			istat_r <= '0;
			imask_r <= '0;
			irq_r <= 1'b0;
			wake_r <= 1'b0;
			oversize_r <= 1'b0;
			rdata_r <= RST_WORD;
		end else begin
			tag1_r <= tag1_nxt;
			tag2_r <= tag2_nxt;
			uni_en_r <= uni_en_nxt;
			frame_en_r <= frame_en_nxt;
			pkt_en_r <= pkt_en_nxt;
			frame_seen_r <= frame_seen_nxt;
			pkt_seen_r <= pkt_seen_nxt;
			istat_r <= istat_nxt;
			imask_r <= imask_nxt;
			irq_r <= irq_nxt;
			wake_r <= wake_nxt;
			oversize_r <= oversize_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence tag_byte_s(logic [15:0] t);
		rx_valid && pos == POS_TAG_LO && {tag_hi_r, rx_data} == t;
	endsequence
	sequence good_end_s;
		rx_valid && rx_eof && rx_good;
	endsequence

	filter_read_a: assert property (reg_rd && reg_addr == OFS_FILT |=> reg_rdata == 32'h0)
		else $error("Filter port read returned data.");
	tag1_match_a: assert property (tag_byte_s(tag1_r) |=> tag1_hit)
		else $error("First tag not flagged.");
	tag2_match_a: assert property (tag_byte_s(tag2_r) |=> tag2_hit)
		else $error("Second tag not flagged.");
	len_limit_a: assert property ((tag1_hit || tag2_hit) == (frame_len_max == 12'd1522))
		else $error("Legal length disagrees with tag flags.");
	frame_seen_a: assert property (good_end_s ##0 (frame_en_r && wif.frame_match)
		|=> frame_seen_r && wake_event)
		else $error("Wake frame not recorded.");
	frame_off_a: assert property (!frame_en_r && !frame_seen_r && !wr_wcsr
		|=> !frame_seen_r)
		else $error("Wake frame flagged while disabled.");
	packet_seen_a: assert property (good_end_s ##0 (pkt_en_r && mp_nxt == MP_FOUND)
		|=> pkt_seen_r && wake_event)
		else $error("Wake packet not recorded.");
	packet_off_a: assert property (!pkt_en_r && !pkt_seen_r && !wr_wcsr |=> !pkt_seen_r)
		else $error("Wake packet flagged while disabled.");
	unicast_wake_a: assert property (good_end_s ##0 (uni_en_r && power_save && !da0_now)
		|=> wake_event && istat_r[IRQ_UNI])
		else $error("Unicast wake missed.");
	// A wake pulse must follow a good frame end and leave a wake status bit behind.
	wake_pulse_a: assert property (wake_event |-> $past(end_ok) &&
		(istat_r[IRQ_FRAME] || istat_r[IRQ_PKT] || istat_r[IRQ_UNI]))
		else $error("Wake pulse without a good frame end and a status bit.");
	irq_level_a: assert property (irq == |(istat_r & imask_r))
		else $error("Interrupt does not follow masked status.");

endmodule

// ===== mvtwf_station.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Remote station that sends whole frames to the receive port
// ---------------------------------------------------------------
module mvtwf_station (
	input wire logic sys_clk, // System clock.
	output logic rx_valid, // Byte valid.
	output logic rx_sof, // First byte of a frame.
	output logic rx_eof, // Last byte of a frame.
	output logic rx_good, // Frame good, with the last byte.
	output logic [7:0] rx_data // Receive byte.
);
	logic [7:0] fr[$];

	// Lines start idle before the first frame.
	initial begin
		{rx_valid, rx_sof, rx_eof, rx_good} = 4'h0;
		rx_data = 8'h00;
	end

	// Idle cycles carry the inverse of the last byte, so stale data never looks valid.
	task automatic send(input logic good, input logic slow);
		int n;
		n = fr.size();
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			rx_valid <= 1'b1;
			rx_sof <= (i == 0);
			rx_eof <= (i == n - 1);
			rx_good <= (i == n - 1) && good;
			rx_data <= fr[i];
			// A slow sender leaves gaps inside the frame.
			if (slow && (i % 7 == 3)) begin
				@(posedge sys_clk);
				{rx_valid, rx_sof, rx_eof, rx_good} <= 4'h0;
				rx_data <= ~fr[i];
			end
		end
		@(posedge sys_clk);
		{rx_valid, rx_sof, rx_eof, rx_good} <= 4'h0;
		rx_data <= ~fr[n - 1];
	endtask
endmodule

// ===== mvtwf_tb.sv
`timescale 1ns/1ns
module tb;
	import mvtwf_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic rx_valid, rx_sof, rx_eof, rx_good;
	logic [7:0] rx_data;
	logic [47:0] station_addr = 48'h0;
	logic power_save = 1'b0;
	logic tag1_hit, tag2_hit, oversize, wake_event, irq;
	logic [11:0] frame_len_max;
	int fails = 0;
	int compares = 0;
	int wk = 0;
	int ov = 0;
	int cyc = 0;
	int o0;
	logic rd_d = 1'b0;
	logic [31:0] rq[$];
	logic [31:0] m;
	logic [15:0] crc;
	logic [15:0] tg[4] = '{16'h8100, 16'h88A8, 16'h0800, 16'h0800};
	int ln[4] = '{1522, 1523, 1518, 1519};

	always #5 sys_clk = ~sys_clk;

	mvtwf_station u_mvtwf_station (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_sof(rx_sof),
		.rx_eof(rx_eof), .rx_good(rx_good), .rx_data(rx_data));

	mvtwf_top u_mvtwf_top (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_good(rx_good),
		.rx_data(rx_data), .station_addr(station_addr), .power_save(power_save),
		.tag1_hit(tag1_hit), .tag2_hit(tag2_hit), .frame_len_max(frame_len_max),
		.oversize(oversize), .wake_event(wake_event), .irq(irq));

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Register read data results.
	task chk_rd(input logic [31:0] got, input logic [31:0] exp);
		chk(got, exp);
	endtask

	// Counted event results, such as wake pulses per frame.
	task chk_ev(input logic [31:0] got, input logic [31:0] exp);
		chk(got, exp);
	endtask

	task test_done;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Read data stands only one cycle, so the oldest note is matched right then.
	always @(posedge sys_clk) begin
		rd_d <= reg_rd;
		cyc++;
		if (wake_event === 1'b1) wk++;
		if (oversize === 1'b1) ov++;
		if (rd_d) chk_rd(reg_rdata, rq.pop_front()); // read data as noted.
		if (cyc == 40000) begin
			fails++;
			test_done();
		end
	end

	// ---------------------------------------------------------------
	// Register port and frame helpers
	// ---------------------------------------------------------------
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [31:0] e);
		rq.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask

	task mk(input int len, input logic [7:0] b0, input logic [15:0] t);
		u_mvtwf_station.fr.delete();
		for (int i = 0; i < len; i++) u_mvtwf_station.fr.push_back(8'($urandom));
		u_mvtwf_station.fr[0] = b0;
		u_mvtwf_station.fr[12] = t[15:8];
		u_mvtwf_station.fr[13] = t[7:0];
	endtask

	// Sends the frame and counts the wake pulses it caused.
	task tx(input logic good, input logic [31:0] ev);
		int w0;
		w0 = wk;
		u_mvtwf_station.send(good, 1'($urandom));
		repeat (3) @(posedge sys_clk);
		chk_ev(32'(wk - w0), ev); // wake pulses per frame.
	endtask

	// Bits are taken low first; the register shifts its top bit out.
	function automatic logic [15:0] crc16(input logic [31:0] mk_bits);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 0; i < 32; i++) begin
			for (int j = 0; j < 8; j++) begin
				if (mk_bits[i]) c = {c[14:0], 1'b0} ^ ((c[15] ^ u_mvtwf_station.fr[i][j]) ? 16'h8005 : 16'h0);
			end
		end
		return c;
	endfunction

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(32'h5D2CA798));
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		station_addr <= {16'($urandom), 32'($urandom)};
		chk(frame_len_max, 32'h5EE); // untagged limit after reset.
		for (int a = 9; a < 16; a++) rd(4'(a), 32'h0); // all read zero, unmapped too.
		wr(OFS_TAG1, 32'hFFFF_8100); // software sets the tag value.
		wr(OFS_TAG2, 32'h0000_88A8);
		rd(OFS_TAG1, 32'h0000_8100); // upper bits are reserved.
		rd(OFS_TAG2, 32'h0000_88A8); // second field held apart.
		// Tagged and untagged frames at and beyond each length limit.
		for (int k = 0; k < 4; k++) begin
			mk(ln[k], 8'h01, tg[k]);
			o0 = ov;
			tx(1'b1, 32'h0); // no wake source enabled.
			chk(tag1_hit, k == 0); // first tag compare.
			chk(tag2_hit, k == 1); // second tag compare.
			chk(frame_len_max, (k < 2) ? 32'h5F2 : 32'h5EE); // tagged limit, untagged limit for k of 2 and 3.
			chk(32'(ov - o0), k % 2); // oversize only past the limit.
		end
		rd(OFS_ISTAT, 32'h8);
		wr(OFS_IMASK, 32'h8);
		repeat (2) @(posedge sys_clk);
		chk(irq, 32'h1);
		wr(OFS_ISTAT, 32'h8);
		repeat (2) @(posedge sys_clk);
		chk(irq, 32'h0);
		// Two passes: the first holds a wrong check value, the wrap must overwrite it.
		mk(64, 8'h01, 16'h0800);
		m = $urandom | 32'h1;
		crc = crc16(m);
		for (int p = 0; p < 2; p++) begin
			for (int e = 0; e < 8; e++) begin
				wr(OFS_FILT, (e == 0) ? m : (e == 4) ? 32'h1 : (e == 6) ?
					{16'h0, crc ^ 16'(p == 0)} : $urandom); // order and wrap.
			end
		end
		rd(OFS_FILT, 32'h0); // no read path.
		wr(OFS_WCSR, 32'h4);
		wr(OFS_IMASK, 32'hF);
		tx(1'b1, 32'h1); // matching frame wakes.
		chk(irq, 32'h1);
		rd(OFS_WCSR, 32'h44); // frame flag set.
		rd(OFS_ISTAT, 32'h1);
		tx(1'b0, 32'h0); // bad frame ignored.
		wr(OFS_WCSR, 32'h44);
		rd(OFS_WCSR, 32'h4);
		wr(OFS_WCSR, 32'h0);
		tx(1'b1, 32'h0); // detection off.
		wr(OFS_ISTAT, 32'hF);
		// Sync run then sixteen copies of the own address.
		mk(130, 8'h01, 16'h0800);
		for (int i = 0; i < 6; i++) u_mvtwf_station.fr[20 + i] = 8'hFF;
		for (int i = 0; i < 96; i++) u_mvtwf_station.fr[26 + i] = station_addr[8 * (i % 6) +: 8];
		wr(OFS_WCSR, 32'h2);
		tx(1'b1, 32'h1); // packet wakes.
		rd(OFS_WCSR, 32'h22); // packet flag set.
		rd(OFS_ISTAT, 32'h2); // packet status bit set.
		wr(OFS_WCSR, 32'h0);
		tx(1'b1, 32'h0); // detection off.
		wr(OFS_ISTAT, 32'hF);
		wr(OFS_WCSR, 32'h200);
		@(posedge sys_clk);
		power_save <= 1'b1;
		mk(64, 8'h02, 16'h0800);
		tx(1'b1, 32'h1); // unicast wakes.
		rd(OFS_ISTAT, 32'h4);
		mk(64, 8'h03, 16'h0800);
		tx(1'b1, 32'h0); // group address does not wake.
		test_done();
	end
endmodule
